// ==== include/cmp_switch_pkg.sv ====
// Package with register map, field positions and reset values of the comparator switch control.
package cmp_switch_pkg;

    // ****************************************************************
    // Register offsets (byte addresses on APB)
    // ****************************************************************
    localparam logic [7:0] cmp_a_ctrl0_addr = 8'h00;
    localparam logic [7:0] cmp_a_ctrl1_addr = 8'h04;
    localparam logic [7:0] cmp_b_ctrl0_addr = 8'h08;
    localparam logic [7:0] cmp_b_ctrl1_addr = 8'h0c;
    localparam logic [7:0] amp_route_addr   = 8'h10;

    // ****************************************************************
    // Field positions in the first control register of each comparator
    // ****************************************************************
    localparam int ctrl0_result_bit = 7;
    localparam int ctrl0_ocm_bit    = 6;
    localparam int ctrl0_ref_bit    = 5;
    localparam int ctrl0_trim_lsb   = 0;
    localparam int trim_width       = 5;

    // ****************************************************************
    // Field positions in the second control register of each comparator
    // ****************************************************************
    localparam int ctrl1_cnp_sel_bit = 7;
    localparam int ctrl1_edge_lsb    = 6;
    localparam int ctrl1_inten_bit   = 3;
    localparam int ctrl1_pin_en_bit  = 2;
    localparam int ctrl1_src_sel_bit = 1;
    localparam int ctrl1_on_bit      = 0;

    // ****************************************************************
    // Field positions in the amplifier routing register
    // ****************************************************************
    localparam int route_amp_a_bit = 0;
    localparam int route_amp_b_bit = 1;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [4:0] trim_reset    = 5'h10;
    localparam logic       cnp_sel_reset = 1'b1;
    localparam logic       src_sel_reset = 1'b1;

    // Edge selection codes for the comparator event output.
    typedef enum logic [1:0] {
        edge_off     = 2'b00,
        edge_rising  = 2'b01,
        edge_falling = 2'b10,
        edge_both    = 2'b11
    } edge_sel_e;

endpackage

// ==== rtl/cmp_switch_ctrl.sv ====
// Digital control of two comparators: APB registers, switch network and pin sharing.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

module cmp_switch_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Raw comparator results from the analog cores
    input  wire logic        cmp_a_result_raw,
    input  wire logic        cmp_b_result_raw,
    // Analog controls of comparator A
    output logic             cmp_a_power,
    output logic      [4:0]  cmp_a_trim_field,
    output logic             cmp_a_noninv_input_switch,
    output logic             cmp_a_inv_input_switch,
    output logic             cmp_a_common_mode_short_switch,
    output logic             cmp_a_inv_from_high_ref,
    // Analog controls of comparator B
    output logic             cmp_b_power,
    output logic      [4:0]  cmp_b_trim_field,
    output logic             cmp_b_noninv_input_switch,
    output logic             cmp_b_inv_input_switch,
    output logic             cmp_b_common_mode_short_switch,
    output logic             cmp_b_noninv_from_low_ref,
    // Shared switch network
    output logic             shared_pin_switch,
    output logic             cmp_a_pin_switch,
    output logic             cmp_b_pin_switch,
    output logic             amp_a_output_switch,
    output logic             amp_b_output_switch,
    // Pin sharing: analog input selects, high means the pin leaves general I/O
    output logic             port_a_line0_analog,
    output logic             port_c_line5_analog,
    output logic             port_c_line6_analog,
    // Pin sharing: comparator output pins
    output logic             port_a_line1_cmp_sel,
    output logic             port_a_line1_cmp_out,
    output logic             port_a_line2_cmp_sel,
    output logic             port_a_line2_cmp_out,
    // Edge event of either synchronised result
    output logic             cmp_edge_event
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic        a_ocm;
        logic        a_ref;
        logic [4:0]  a_trim;
        logic        cnp_sel;
        logic        a_inten;
        logic        a_pin_en;
        logic        a_inv_sel;
        logic        a_on;
        logic        b_ocm;
        logic        b_ref;
        logic [4:0]  b_trim;
        logic [1:0]  b_edge;
        logic        b_inten;
        logic        b_pin_en;
        logic        b_noninv_sel;
        logic        b_on;
        logic        route_a;
        logic        route_b;
        logic [1:0]  a_sync;
        logic [1:0]  b_sync;
        logic        a_prev;
        logic        b_prev;
        logic [31:0] rdata;
        logic [18:0] sw;
        logic        event_q;
    } state_s;

    state_s state;
    state_s next_state;

    // Effective (forced) control values.
    logic a_cal;
    logic b_cal;
    logic cnp_eff;
    logic a_inv_eff;
    logic b_noninv_eff;
    logic route_a_eff;
    logic route_b_eff;
    logic a_res;
    logic b_res;
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;
    logic [18:0] next_sw;
    logic a_edge_hit;
    logic b_edge_hit;

    // ****************************************************************
    // Forcing of source and routing bits
    // ****************************************************************
    // Written values stay in the registers while calibration forces the effective value,
    // so leaving calibration brings the old setting back with no extra storage.
    always_comb begin
        a_cal        = state.a_ocm;
        b_cal        = state.b_ocm;
        cnp_eff      = state.cnp_sel | a_cal | b_cal;
        a_inv_eff    = state.a_inv_sel | a_cal;
        b_noninv_eff = state.b_noninv_sel | b_cal;
        route_a_eff  = state.route_a & ~cnp_eff;
        route_b_eff  = state.route_b & ~cnp_eff & ~route_a_eff;
        a_res        = state.a_sync[1];
        b_res        = state.b_sync[1];
    end

    // ****************************************************************
    // APB decode and read data
    // ****************************************************************
    // The slave never waits; errors flag only unmapped offsets.
    always_comb begin
        setup  = psel & ~penable;
        wr     = psel & penable & pwrite & pstrb[0];
        mapped = (paddr == cmp_switch_pkg::cmp_a_ctrl0_addr) |
                 (paddr == cmp_switch_pkg::cmp_a_ctrl1_addr) |
                 (paddr == cmp_switch_pkg::cmp_b_ctrl0_addr) |
                 (paddr == cmp_switch_pkg::cmp_b_ctrl1_addr) |
                 (paddr == cmp_switch_pkg::amp_route_addr);
        rd_mux = 32'h0000_0000;
        case (paddr)
            cmp_switch_pkg::cmp_a_ctrl0_addr: begin
                rd_mux[cmp_switch_pkg::ctrl0_result_bit] = a_res;
                rd_mux[cmp_switch_pkg::ctrl0_ocm_bit]    = state.a_ocm;
                rd_mux[cmp_switch_pkg::ctrl0_ref_bit]    = state.a_ref;
                rd_mux[4:0]                              = state.a_trim;
            end
            cmp_switch_pkg::cmp_a_ctrl1_addr: begin
                rd_mux[cmp_switch_pkg::ctrl1_cnp_sel_bit] = cnp_eff;
                rd_mux[cmp_switch_pkg::ctrl1_inten_bit]   = state.a_inten;
                rd_mux[cmp_switch_pkg::ctrl1_pin_en_bit]  = state.a_pin_en;
                rd_mux[cmp_switch_pkg::ctrl1_src_sel_bit] = a_inv_eff;
                rd_mux[cmp_switch_pkg::ctrl1_on_bit]      = state.a_on;
            end
            cmp_switch_pkg::cmp_b_ctrl0_addr: begin
                rd_mux[cmp_switch_pkg::ctrl0_result_bit] = b_res;
                rd_mux[cmp_switch_pkg::ctrl0_ocm_bit]    = state.b_ocm;
                rd_mux[cmp_switch_pkg::ctrl0_ref_bit]    = state.b_ref;
                rd_mux[4:0]                              = state.b_trim;
            end
            cmp_switch_pkg::cmp_b_ctrl1_addr: begin
                rd_mux[7:6]                               = state.b_edge;
                rd_mux[cmp_switch_pkg::ctrl1_inten_bit]   = state.b_inten;
                rd_mux[cmp_switch_pkg::ctrl1_pin_en_bit]  = state.b_pin_en;
                rd_mux[cmp_switch_pkg::ctrl1_src_sel_bit] = b_noninv_eff;
                rd_mux[cmp_switch_pkg::ctrl1_on_bit]      = state.b_on;
            end
            cmp_switch_pkg::amp_route_addr: begin
                rd_mux[cmp_switch_pkg::route_amp_a_bit] = route_a_eff;
                rd_mux[cmp_switch_pkg::route_amp_b_bit] = route_b_eff;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Switch and pin controls
    // ****************************************************************
    // Bit order of next_sw matches the output assignments further down.
    always_comb begin
        next_sw = '0;
        // Comparator A input switches; firmware steps the trim in calibration.
        next_sw[0]  = ~a_cal | state.a_ref;
        next_sw[1]  = ~a_cal | ~state.a_ref;
        next_sw[2]  = a_cal;
        // Comparator B uses the same reference convention.
        next_sw[3]  = ~b_cal | state.b_ref;
        next_sw[4]  = ~b_cal | ~state.b_ref;
        next_sw[5]  = b_cal;
        // Shared non-inverting pin only while some comparator uses it.
        next_sw[6]  = cnp_eff & (state.a_on | state.b_on | a_cal | b_cal);
        next_sw[7]  = a_inv_eff & (state.a_on | a_cal);
        next_sw[8]  = b_noninv_eff & (state.b_on | b_cal);
        next_sw[9]  = route_a_eff & (state.a_on | state.b_on);
        next_sw[10] = route_b_eff & (state.a_on | state.b_on);
        next_sw[11] = state.a_on & ~a_inv_eff;
        next_sw[12] = state.b_on & ~b_noninv_eff;
        next_sw[13] = state.a_on & state.a_pin_en;
        next_sw[14] = a_res;
        next_sw[15] = state.b_on & state.b_pin_en;
        next_sw[16] = b_res;
        next_sw[17] = state.a_on | a_cal;
        next_sw[18] = state.b_on | b_cal;
    end

    // ****************************************************************
    // Edge detection on the synchronised results
    // ****************************************************************
    always_comb begin
        a_edge_hit = 1'b0;
        b_edge_hit = 1'b0;
        case (cmp_switch_pkg::edge_sel_e'(state.b_edge))
            cmp_switch_pkg::edge_rising: begin
                a_edge_hit = a_res & ~state.a_prev;
                b_edge_hit = b_res & ~state.b_prev;
            end
            cmp_switch_pkg::edge_falling: begin
                a_edge_hit = ~a_res & state.a_prev;
                b_edge_hit = ~b_res & state.b_prev;
            end
            cmp_switch_pkg::edge_both: begin
                a_edge_hit = a_res ^ state.a_prev;
                b_edge_hit = b_res ^ state.b_prev;
            end
            default: begin
                a_edge_hit = 1'b0;
                b_edge_hit = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Register writes take effect at the access edge; read data is caught in setup.
    always_comb begin
        next_state         = state;
        next_state.a_sync  = {state.a_sync[0], cmp_a_result_raw};
        next_state.b_sync  = {state.b_sync[0], cmp_b_result_raw};
        next_state.a_prev  = a_res;
        next_state.b_prev  = b_res;
        next_state.sw      = next_sw;
        next_state.event_q = (a_edge_hit & state.a_on) | (b_edge_hit & state.b_on);
        if (setup) begin
            next_state.rdata = rd_mux;
        end
        if (wr) begin
            case (paddr)
                cmp_switch_pkg::cmp_a_ctrl0_addr: begin
                    next_state.a_ocm  = pwdata[cmp_switch_pkg::ctrl0_ocm_bit];
                    next_state.a_ref  = pwdata[cmp_switch_pkg::ctrl0_ref_bit];
                    next_state.a_trim = pwdata[4:0];
                end
                cmp_switch_pkg::cmp_a_ctrl1_addr: begin
                    next_state.cnp_sel   = pwdata[cmp_switch_pkg::ctrl1_cnp_sel_bit];
                    next_state.a_inten   = pwdata[cmp_switch_pkg::ctrl1_inten_bit];
                    next_state.a_pin_en  = pwdata[cmp_switch_pkg::ctrl1_pin_en_bit];
                    next_state.a_inv_sel = pwdata[cmp_switch_pkg::ctrl1_src_sel_bit];
                    next_state.a_on      = pwdata[cmp_switch_pkg::ctrl1_on_bit];
                end
                cmp_switch_pkg::cmp_b_ctrl0_addr: begin
                    next_state.b_ocm  = pwdata[cmp_switch_pkg::ctrl0_ocm_bit];
                    next_state.b_ref  = pwdata[cmp_switch_pkg::ctrl0_ref_bit];
                    next_state.b_trim = pwdata[4:0];
                end
                cmp_switch_pkg::cmp_b_ctrl1_addr: begin
                    next_state.b_edge       = pwdata[7:6];
                    next_state.b_inten      = pwdata[cmp_switch_pkg::ctrl1_inten_bit];
                    next_state.b_pin_en     = pwdata[cmp_switch_pkg::ctrl1_pin_en_bit];
                    next_state.b_noninv_sel = pwdata[cmp_switch_pkg::ctrl1_src_sel_bit];
                    next_state.b_on         = pwdata[cmp_switch_pkg::ctrl1_on_bit];
                end
                cmp_switch_pkg::amp_route_addr: begin
                    next_state.route_a = pwdata[cmp_switch_pkg::route_amp_a_bit];
                    next_state.route_b = pwdata[cmp_switch_pkg::route_amp_b_bit];
                end
                default: begin
                    next_state.rdata = state.rdata;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset values leave every comparator off and every pin as general I/O.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= '0;
            state.a_trim       <= cmp_switch_pkg::trim_reset;
            state.b_trim       <= cmp_switch_pkg::trim_reset;
            state.cnp_sel      <= cmp_switch_pkg::cnp_sel_reset;
            state.a_inv_sel    <= cmp_switch_pkg::src_sel_reset;
            state.b_noninv_sel <= cmp_switch_pkg::src_sel_reset;
            state.sw           <= 19'h0001b;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Handshake outputs are combinational; everything else comes from flops.
    assign pready                         = 1'b1;
    assign pslverr                        = psel & penable & ~mapped;
    assign prdata                         = state.rdata;
    assign cmp_a_trim_field               = state.a_trim;
    assign cmp_b_trim_field               = state.b_trim;
    assign cmp_a_noninv_input_switch      = state.sw[0];
    assign cmp_a_inv_input_switch         = state.sw[1];
    assign cmp_a_common_mode_short_switch = state.sw[2];
    assign cmp_b_noninv_input_switch      = state.sw[3];
    assign cmp_b_inv_input_switch         = state.sw[4];
    assign cmp_b_common_mode_short_switch = state.sw[5];
    assign shared_pin_switch              = state.sw[6];
    assign cmp_a_pin_switch               = state.sw[7];
    assign cmp_b_pin_switch               = state.sw[8];
    assign amp_a_output_switch            = state.sw[9];
    assign amp_b_output_switch            = state.sw[10];
    assign cmp_a_inv_from_high_ref        = state.sw[11];
    assign cmp_b_noninv_from_low_ref      = state.sw[12];
    assign port_a_line0_analog            = state.sw[6];
    assign port_c_line5_analog            = state.sw[7];
    assign port_c_line6_analog            = state.sw[8];
    assign port_a_line1_cmp_sel           = state.sw[13];
    assign port_a_line1_cmp_out           = state.sw[14];
    assign port_a_line2_cmp_sel           = state.sw[15];
    assign port_a_line2_cmp_out           = state.sw[16];
    assign cmp_a_power                    = state.sw[17];
    assign cmp_b_power                    = state.sw[18];
    assign cmp_edge_event                 = state.event_q;

endmodule

// ==== test/cmp_switch_ctrl_props.sv ====
// Checker with concurrent properties on the comparator switch control ports.
`timescale 1ns/1ps
module cmp_switch_ctrl_props (
    // Clock, reset and bus
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Comparator result path
    input wire logic       cmp_a_result_raw,
    input wire logic       port_a_line1_cmp_out,
    // Switch network
    input wire logic       cmp_a_noninv_input_switch,
    input wire logic       cmp_a_inv_input_switch,
    input wire logic       cmp_a_common_mode_short_switch,
    input wire logic       cmp_b_common_mode_short_switch,
    input wire logic       shared_pin_switch,
    input wire logic       cmp_a_pin_switch,
    input wire logic       cmp_b_pin_switch,
    input wire logic       amp_a_output_switch,
    input wire logic       amp_b_output_switch
);
    // All properties share the bus clock; reset masks the switch defaults.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
        else $error("no error on unmapped access");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_cal_a_pins: assert property (cmp_a_common_mode_short_switch |->
        shared_pin_switch && cmp_a_pin_switch) else $error("calibration pins open");
    a_normal_inputs: assert property (!cmp_a_common_mode_short_switch |->
        cmp_a_noninv_input_switch && cmp_a_inv_input_switch) else $error("input switch open");
    a_cal_inputs: assert property (cmp_a_common_mode_short_switch |->
        cmp_a_noninv_input_switch != cmp_a_inv_input_switch) else $error("bad reference");
    a_cal_b_pins: assert property (cmp_b_common_mode_short_switch |->
        shared_pin_switch && cmp_b_pin_switch) else $error("calibration pins open");
    a_amp_forced_open: assert property (shared_pin_switch |->
        !amp_a_output_switch && !amp_b_output_switch) else $error("amplifier on pin input");
    a_amp_exclusive: assert property (!(amp_a_output_switch && amp_b_output_switch))
        else $error("both amplifiers routed");
    a_result_sync: assert property ($rose(cmp_a_result_raw) ##1
        $stable(cmp_a_result_raw) [*2] |=> port_a_line1_cmp_out) else $error("result late");
endmodule

bind cmp_switch_ctrl cmp_switch_ctrl_props i_cmp_switch_ctrl_props (.*);

// ==== test/test_cmp_switch_ctrl.sv ====
// Self-checking testbench of the comparator switch control.
`timescale 1ns/1ps
module test_cmp_switch_ctrl;
    localparam logic [7:0] a0 = cmp_switch_pkg::cmp_a_ctrl0_addr;
    localparam logic [7:0] a1 = cmp_switch_pkg::cmp_a_ctrl1_addr;
    localparam logic [7:0] b0 = cmp_switch_pkg::cmp_b_ctrl0_addr;
    localparam logic [7:0] b1 = cmp_switch_pkg::cmp_b_ctrl1_addr;
    localparam logic [7:0] rt = cmp_switch_pkg::amp_route_addr;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        cmp_a_result_raw, cmp_b_result_raw, port_a_line0_analog, port_c_line5_analog;
    logic        cmp_a_noninv_input_switch, cmp_a_inv_input_switch, cmp_a_inv_from_high_ref;
    logic        cmp_a_common_mode_short_switch, cmp_b_common_mode_short_switch;
    logic        cmp_b_noninv_from_low_ref, shared_pin_switch, cmp_a_pin_switch;
    logic        cmp_b_pin_switch, amp_a_output_switch, amp_b_output_switch;
    logic        port_c_line6_analog, port_a_line1_cmp_sel, port_a_line1_cmp_out;
    logic        port_a_line2_cmp_sel, port_a_line2_cmp_out;
    logic        cmp_a_power, cmp_b_power, cmp_b_noninv_input_switch, cmp_b_inv_input_switch;
    logic        cmp_edge_event;
    logic [4:0]  cmp_a_trim_field, cmp_b_trim_field;
    int          bad_count, compares;

    cmp_switch_ctrl i_cmp_switch_ctrl (.*);

    // Free-running 50 MHz bus clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
    endtask

    // Switch outputs trail the register by one edge, so wait three rising edges and look at the falling edge after them.
    task automatic settle;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rd(a0, 32'h10);
        rd(a1, 32'h82);
        rd(b0, 32'h10);
        rd(b1, 32'h02);
        rd(rt, 32'h00);
        apb(1'b0, 8'h14, 32'h0, q, e);
        check({q[30:0], e}, 32'h1);
    endtask

    task automatic t_cal_a;
        wr(a1, 32'h01);
        wr(a0, 32'h50);
        settle;
        check({cmp_a_common_mode_short_switch, cmp_a_noninv_input_switch}, 2'b10);
        check({shared_pin_switch, cmp_a_pin_switch, cmp_a_inv_input_switch}, 3'b111);
        rd(a1, 32'h83);
        wr(a0, 32'h73);
        settle;
        check({cmp_a_noninv_input_switch, cmp_a_inv_input_switch}, 2'b10);
        check(cmp_a_trim_field, 5'h13);
        wr(a0, 32'h10);
        settle;
        check({cmp_a_common_mode_short_switch, cmp_a_noninv_input_switch}, 2'b01);
        rd(a1, 32'h01);
        check({shared_pin_switch, cmp_a_inv_from_high_ref}, 2'b01);
    endtask

    task automatic t_cal_b;
        wr(a1, 32'h00);
        wr(b1, 32'h01);
        settle;
        check(cmp_b_noninv_from_low_ref, 1'b1);
        check({cmp_a_power, cmp_b_power}, 2'b01);
        wr(b0, 32'h50);
        settle;
        check({shared_pin_switch, cmp_b_pin_switch, cmp_b_common_mode_short_switch}, 3'h7);
        check({cmp_b_noninv_input_switch, cmp_b_inv_input_switch, cmp_b_trim_field}, 7'h30);
        rd(b1, 32'h03);
        rd(a1, 32'h80);
        wr(b0, 32'h10);
        settle;
        rd(b1, 32'h01);
        check({shared_pin_switch, cmp_b_pin_switch}, 2'b00);
        wr(b1, 32'h00);
    endtask

    task automatic t_route;
        wr(a1, 32'h01);
        wr(rt, 32'h03);
        settle;
        rd(rt, 32'h01);
        check({amp_a_output_switch, amp_b_output_switch}, 2'b10);
        wr(a1, 32'h81);
        settle;
        rd(rt, 32'h00);
        check({amp_a_output_switch, amp_b_output_switch, shared_pin_switch}, 3'b001);
        wr(a1, 32'h01);
        wr(rt, 32'h02);
        settle;
        check({amp_a_output_switch, amp_b_output_switch, shared_pin_switch}, 3'b010);
        wr(rt, 32'h00);
    endtask

    // Pins stay general I/O while off, then carry the synchronised results.
    task automatic t_pins;
        wr(a1, 32'h86);
        settle;
        check({port_a_line0_analog, port_c_line5_analog, port_a_line1_cmp_sel}, 3'b0);
        wr(a1, 32'h87);
        settle;
        check({port_a_line0_analog, port_c_line5_analog, port_a_line1_cmp_sel}, 3'h7);
        @(posedge pclk);
        cmp_a_result_raw <= 1'b1;
        settle;
        rd(a0, 32'h90);
        check(port_a_line1_cmp_out, 1'b1);
        wr(b1, 32'h06);
        settle;
        check({port_c_line6_analog, port_a_line2_cmp_sel}, 2'b00);
        wr(b1, 32'h07);
        settle;
        check({port_c_line6_analog, port_a_line2_cmp_sel}, 2'b11);
        @(posedge pclk);
        cmp_b_result_raw <= 1'b1;
        settle;
        rd(b0, 32'h90);
        check(port_a_line2_cmp_out, 1'b1);
    endtask

    // A falling result gives one event pulse; with edge select off a change gives none.
    task automatic t_edge;
        int hits;
        wr(b1, 32'h87);
        cmp_a_result_raw <= 1'b0;
        hits = 0;
        repeat (8) begin
            @(negedge pclk);
            hits += cmp_edge_event;
        end
        check(hits, 1);
        wr(b1, 32'h07);
        cmp_b_result_raw <= 1'b0;
        hits = 0;
        repeat (8) begin
            @(negedge pclk);
            hits += cmp_edge_event;
        end
        check(hits, 0);
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence: five cycles of reset, then every scenario in turn.
    initial begin
        {presetn, psel, penable, pwrite, cmp_a_result_raw, cmp_b_result_raw} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_cal_a;
        t_cal_b;
        t_route;
        t_pins;
        t_edge;
        print_verdict;
    end

    // The scenarios need far less than this; a hang ends the run here.
    initial begin
        #100000;
        bad_count++;
        print_verdict;
    end
endmodule
